/* core/fsic_map.svh */
`ifndef FSIC_MAP_SVH
`define FSIC_MAP_SVH

// Control bus offsets.
`define FSIC_ADDR_TSC     8'h04
`define FSIC_ADDR_THR     8'h05
`define FSIC_ADDR_CNT     8'h1A

// Transmit state control field positions.
`define FSIC_TM_LSB       0
`define FSIC_TM_MSB       2
`define FSIC_IC_LO        3
`define FSIC_IC_HI        4
`define FSIC_SMOOTH       5
`define FSIC_PARITY       6
`define FSIC_RSV          7

// Reset values.
`define FSIC_TSC_RESET    8'hA2
`define FSIC_THR_RESET    8'h00
`define FSIC_CNT_RESET    8'h00

// Symbol pair timing.
`define FSIC_CLK_NS       10
`define FSIC_PAIR_NS      80
`define FSIC_PAIR_CYC     (`FSIC_PAIR_NS / `FSIC_CLK_NS)

// Idle pair used to fill an empty stream while the smoother is on.
`define FSIC_IDLE_PAIR    10'h3FF

`endif

/* core/fsic_pkg.sv */
// Purpose: Types shared by the symbol injection control block.
// Assumes: Constants come from fsic_map.svh.
// Notes:   Enum order gives the injection control field encoding.
package fsic_pkg;

    typedef enum logic [1:0] {
        FSIC_INJ_NONE,
        FSIC_INJ_ONESHOT,
        FSIC_INJ_PERIODIC,
        FSIC_INJ_CONT
    } fsic_inj_e;

    typedef struct packed {
        logic       jk;
        logic [9:0] sym;
    } fsic_pair_s;

endpackage : fsic_pkg

/* core/fsic_stream_if.sv */
// Purpose: Valid/ready stream carrier between the block's own modules.
// Assumes: One clock domain.
// Notes:   src drives data, snk takes it.
interface fsic_stream_if #(
    parameter int W = 11
);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : fsic_stream_if

/* core/fsic_fifo.sv */
// Purpose: Request pair buffer between the MAC side and the pair-rate output.
// Assumes: Same clock on both sides.
// Notes:   Full and empty are exact; the reader stalls by holding ready low.
module fsic_fifo #(
    parameter int W     = 11,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rstn,
    // Streams
    fsic_stream_if.snk  wr,
    fsic_stream_if.src  rd,
    // Status
    output logic        full,
    output logic        empty
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wptr_q;
    logic [AW:0]  rptr_q;

    wire do_wr = wr.valid && wr.ready;
    wire do_rd = rd.valid && rd.ready;

    assign full     = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
    assign empty    = (wptr_q == rptr_q);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem[rptr_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wptr_q[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            if (do_wr) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (do_rd) begin
                rptr_q <= rptr_q + 1'b1;
            end
        end
    end

endmodule : fsic_fifo

/* core/fsic_top.sv */
// Purpose: Transmit symbol injection and transmit state control.
// Assumes: Request pairs and control bus come from logic on clk.
// Notes:   One output pair slot every symbol-pair period.
`include "fsic_map.svh"

module fsic_top
    import fsic_pkg::*;
#(
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Control bus
    input  wire logic [7:0] cb_addr,
    input  wire logic [7:0] cb_wdata,
    input  wire logic       cb_wr,
    input  wire logic       cb_rd,
    output logic      [7:0] cb_rdata,
    output logic            cb_write_reject,
    // Trigger copy in progress
    input  wire logic       trig_copy_busy,
    // Injection symbols in 5B code
    input  wire logic [4:0] inject_symbol_first,
    input  wire logic [4:0] inject_symbol_second,
    // MAC request pairs
    input  wire logic       req_valid,
    output logic            req_ready,
    input  wire logic [9:0] req_pair,
    input  wire logic       req_jk,
    input  wire logic       req_parity,
    // Transmit pairs
    output logic            tx_valid,
    output logic      [9:0] tx_pair,
    output logic            tx_injected,
    // Status and control levels
    output logic            parity_error,
    output logic            smoother_on,
    output logic            request_parity_on,
    output logic      [2:0] tx_mode
);

    ////////////////////////////////////////////////////////////////////////////
    // Control bus decode

    localparam logic [3:0] PAIR_LAST = 4'(`FSIC_PAIR_CYC - 1);

    logic [7:0] tsc_q;
    logic [7:0] tsc_d;
    logic [7:0] thr_q;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       armed_q;
    logic       armed_d;
    logic [3:0] div_q;
    logic [7:0] rdata_q;
    logic       reject_q;
    logic       perr_q;
    logic       txv_q;
    logic [9:0] txp_q;
    logic       txi_q;

    wire sel_tsc   = (cb_addr == `FSIC_ADDR_TSC);
    wire sel_thr   = (cb_addr == `FSIC_ADDR_THR);
    wire sel_cnt   = (cb_addr == `FSIC_ADDR_CNT);
    wire tsc_wr_ok = cb_wr && sel_tsc && !trig_copy_busy;
    wire tsc_rej   = cb_wr && sel_tsc && trig_copy_busy;
    wire thr_wr    = cb_wr && sel_thr;

    wire [7:0] rd_mux = sel_tsc ? tsc_q :
                        sel_thr ? thr_q :
                        sel_cnt ? cnt_q :
                        8'h00;

    // The reserved bit is stored and read back but steers nothing.
    wire       [1:0] ic_bits = tsc_q[`FSIC_IC_HI:`FSIC_IC_LO];
    fsic_inj_e       mode;
    assign mode = fsic_inj_e'(ic_bits);
    assign smoother_on       = tsc_q[`FSIC_SMOOTH];
    assign request_parity_on = tsc_q[`FSIC_PARITY];
    assign tx_mode           = tsc_q[`FSIC_TM_MSB:`FSIC_TM_LSB];
    assign cb_rdata          = rdata_q;
    assign cb_write_reject   = reject_q;

    ////////////////////////////////////////////////////////////////////////////
    // Request buffer

    fsic_stream_if #(.W(11)) in_s ();
    fsic_stream_if #(.W(11)) out_s ();

    fsic_pair_s in_pair;
    fsic_pair_s head;

    assign in_pair.jk  = req_jk;
    assign in_pair.sym = req_pair;
    assign in_s.data   = in_pair;
    assign in_s.valid  = req_valid;
    assign req_ready   = in_s.ready;
    assign head        = out_s.data;

    fsic_fifo #(
        .W     (11),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk   (clk),
        .rstn  (rstn),
        .wr    (in_s),
        .rd    (out_s),
        .full  (),
        .empty ()
    );

    // Parity bit makes the eleven bits odd.
    wire req_take = req_valid && in_s.ready;
    wire perr_hit = req_take && request_parity_on && !(^{req_pair, req_parity});

    ////////////////////////////////////////////////////////////////////////////
    // Pair slot timing and source selection

    wire tick = (div_q == PAIR_LAST);

    // The buffer drains only at a pair slot, so back-pressure reaches the MAC.
    assign out_s.ready = tick;

    wire       from_fifo = out_s.valid;
    wire       have_pair = from_fifo || smoother_on;
    wire       pair_jk   = from_fifo && head.jk;
    wire [9:0] src_sym   = from_fifo ? head.sym : `FSIC_IDLE_PAIR;
    wire [9:0] inj_sym   = {inject_symbol_first, inject_symbol_second};

    ////////////////////////////////////////////////////////////////////////////
    // Injection counter

    wire       mode_cnt = (mode == FSIC_INJ_ONESHOT) ||
                          (mode == FSIC_INJ_PERIODIC);
    wire [7:0] cnt_eff  = pair_jk ? thr_q : cnt_q;
    wire       armed    = (mode == FSIC_INJ_PERIODIC) || armed_q ||
                          (pair_jk && mode == FSIC_INJ_ONESHOT);
    wire       hit      = tick && mode_cnt && armed && (cnt_eff == 8'h00);
    wire       do_inj   = tick && have_pair &&
                          ((mode == FSIC_INJ_CONT) || hit);
    wire       os_done  = do_inj && (mode == FSIC_INJ_ONESHOT);

    always_comb begin
        cnt_d = cnt_q;
        if (thr_wr) begin
            cnt_d = cb_wdata;
        end else if (tick && mode_cnt) begin
            cnt_d = (cnt_eff == 8'h00) ? thr_q : cnt_eff - 8'h01;
        end
    end

    always_comb begin
        armed_d = armed_q;
        if (mode != FSIC_INJ_ONESHOT) begin
            armed_d = 1'b0;
        end else if (tick) begin
            armed_d = armed && !os_done;
        end
    end

    // A host write in the completion cycle wins over the hardware clear.
    always_comb begin
        tsc_d = tsc_q;
        if (tsc_wr_ok) begin
            tsc_d = cb_wdata;
        end else if (os_done) begin
            tsc_d[`FSIC_IC_LO] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tsc_q   <= `FSIC_TSC_RESET;
            thr_q   <= `FSIC_THR_RESET;
            cnt_q   <= `FSIC_CNT_RESET;
            armed_q <= 1'b0;
            div_q   <= 4'h0;
        end else begin
            tsc_q   <= tsc_d;
            thr_q   <= thr_wr ? cb_wdata : thr_q;
            cnt_q   <= cnt_d;
            armed_q <= armed_d;
            div_q   <= tick ? 4'h0 : div_q + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q  <= 8'h00;
            reject_q <= 1'b0;
            perr_q   <= 1'b0;
        end else begin
            rdata_q  <= cb_rd ? rd_mux : rdata_q;
            reject_q <= tsc_rej;
            perr_q   <= perr_hit;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txv_q <= 1'b0;
            txp_q <= 10'h000;
            txi_q <= 1'b0;
        end else begin
            txv_q <= tick && have_pair;
            if (tick && have_pair) begin
                txp_q <= do_inj ? inj_sym : src_sym;
                txi_q <= do_inj;
            end
        end
    end

    assign parity_error = perr_q;
    assign tx_valid     = txv_q;
    assign tx_pair      = txp_q;
    assign tx_injected  = txi_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb_clk @(posedge clk); endclocking
    default disable iff (!rstn);

    a_none_passes: assert property (
        tick && have_pair && mode == FSIC_INJ_NONE
        |=> tx_valid && !tx_injected && tx_pair == $past(src_sym)
    ) else $error("pair altered with injection off");

    a_cont_replaces: assert property (
        tick && have_pair && mode == FSIC_INJ_CONT
        |=> tx_injected && tx_pair == $past(inj_sym)
    ) else $error("continuous mode did not inject");

    a_cnt_decrement: assert property (
        tick && mode_cnt && !thr_wr && cnt_eff != 8'h00
        |=> cnt_q == $past(cnt_eff) - 8'h01
    ) else $error("counter did not step down by one");

    a_cnt_reload: assert property (
        thr_wr |=> cnt_q == $past(cb_wdata) && thr_q == $past(cb_wdata)
    ) else $error("threshold write did not reload counter");

    a_cnt_idle: assert property (
        !mode_cnt && !thr_wr |=> $stable(cnt_q)
    ) else $error("counter moved outside counting modes");

    a_oneshot_clear: assert property (
        os_done && !tsc_wr_ok
        |=> mode == FSIC_INJ_NONE && tsc_q[7:5] == $past(tsc_q[7:5]) &&
            tsc_q[2:0] == $past(tsc_q[2:0])
    ) else $error("one-shot completion did not clear low bit");

    a_write_reject: assert property (
        tsc_rej && !os_done |=> cb_write_reject && $stable(tsc_q)
    ) else $error("write during trigger copy not refused");

    a_parity_off: assert property (
        !request_parity_on |=> !parity_error
    ) else $error("parity flagged while disabled");

    a_pair_period: assert property (
        tick |=> !tick [*7] ##1 tick
    ) else $error("pair slot period is not eight cycles");

    a_periodic_inject: assert property (
        tick && have_pair && mode == FSIC_INJ_PERIODIC && cnt_eff == 8'h00
        |=> tx_injected
    ) else $error("periodic zero count did not inject");

    a_cnt_zero_reload: assert property (
        tick && mode_cnt && !thr_wr && cnt_eff == 8'h00
        |=> cnt_q == $past(thr_q)
    ) else $error("counter did not reload at zero");

    a_jk_restart: assert property (
        tick && mode_cnt && pair_jk && !thr_wr && thr_q != 8'h00
        |=> cnt_q == $past(thr_q) - 8'h01
    ) else $error("JK pair did not restart the count");

    a_oneshot_place: assert property (
        tick && mode == FSIC_INJ_ONESHOT && pair_jk && thr_q == 8'h00
        |=> tx_injected
    ) else $error("one-shot zero count did not replace the JK pair");

    a_oneshot_wait: assert property (
        tick && have_pair && mode == FSIC_INJ_ONESHOT && !armed_q && !pair_jk
        |=> !tx_injected
    ) else $error("one-shot injected before any JK pair");

    a_inject_symbols: assert property (
        do_inj |=> tx_injected && tx_pair[9:5] == $past(inject_symbol_first) &&
                   tx_pair[4:0] == $past(inject_symbol_second)
    ) else $error("injected pair does not carry both symbols in order");

    a_smoother_fill: assert property (
        tick && smoother_on
        |=> tx_valid
    ) else $error("slot left empty while smoother on");

    a_smoother_off: assert property (
        tick && !smoother_on && !out_s.valid
        |=> !tx_valid
    ) else $error("idle fill sent while smoother off");

    a_tsc_write: assert property (
        tsc_wr_ok
        |=> tsc_q == $past(cb_wdata)
    ) else $error("accepted control write did not land");

    a_thr_stable: assert property (
        !thr_wr |=> $stable(thr_q)
    ) else $error("threshold changed without a write");

    c_oneshot_done: cover property (os_done);
    c_oneshot_jk:   cover property (os_done && pair_jk);
    c_periodic_inj: cover property (do_inj && mode == FSIC_INJ_PERIODIC);
    c_reject:       cover property (tsc_rej);
    c_backpressure: cover property (req_valid && !req_ready);

endmodule : fsic_top

/* verification/fsic_mac_model.sv */
// Purpose: Request side stand-in for the MAC that feeds the block.
// Assumes: One beat is offered per cycle while en is high.
// Notes:   Released pair lines show the inverse of the last value.
module fsic_mac_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Bench controls
    input  wire logic       en,
    input  wire logic       jk_req,
    input  wire logic       bad_par,
    // Request stream
    input  wire logic       req_ready,
    output logic            req_valid,
    output logic      [9:0] req_pair,
    output logic            req_jk,
    output logic            req_parity
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] p;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req_valid  <= 1'b0;
            req_pair   <= 10'h000;
            req_jk     <= 1'b0;
            req_parity <= 1'b0;
        end else if (req_valid && !req_ready) begin
            req_valid <= 1'b1;
        end else if (en) begin
            p = 10'($urandom);
            // The idle pattern is kept off data so the bench can tell them apart.
            if (p == 10'h3FF) p = 10'h3FE;
            req_valid  <= 1'b1;
            req_pair   <= p;
            req_jk     <= jk_req;
            req_parity <= ~^p ^ bad_par;
        end else begin
            req_valid <= 1'b0;
            req_pair  <= ~req_pair;
            req_jk    <= 1'b0;
        end
    end
endmodule : fsic_mac_model

/* verification/fsic_top_bench.sv */
// Purpose: Self-checking bench for the symbol injection control block.
// Assumes: fsic_mac_model supplies request beats.
// Notes:   Checks pass-through, injection modes, counter and control bus.
`include "fsic_map.svh"
module fsic_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rstn, cb_wr, cb_rd, trig_copy_busy, en, jk_req, bad_par;
    logic [7:0] cb_addr, cb_wdata, cb_rdata, v, a;
    logic [4:0] sym_a, sym_b;
    logic       req_valid, req_ready, req_jk, req_parity, tx_valid, tx_injected;
    logic       cb_write_reject, parity_error, smoother_on, request_parity_on;
    logic [9:0] req_pair, tx_pair, jk_val;
    logic [2:0] tx_mode;
    logic [9:0] q[$];
    int         n_fail, comparisons, slots, injs, js, is, rejs, pes, md, s0, i0, k;

    fsic_top #(.DEPTH(32)) uut (.clk(clk), .rstn(rstn), .cb_addr(cb_addr),
        .cb_wdata(cb_wdata), .cb_wr(cb_wr), .cb_rd(cb_rd), .cb_rdata(cb_rdata),
        .cb_write_reject(cb_write_reject), .trig_copy_busy(trig_copy_busy),
        .inject_symbol_first(sym_a), .inject_symbol_second(sym_b),
        .req_valid(req_valid), .req_ready(req_ready), .req_pair(req_pair),
        .req_jk(req_jk), .req_parity(req_parity), .tx_valid(tx_valid),
        .tx_pair(tx_pair), .tx_injected(tx_injected), .parity_error(parity_error),
        .smoother_on(smoother_on), .request_parity_on(request_parity_on),
        .tx_mode(tx_mode));
    fsic_mac_model mac (.clk(clk), .rstn(rstn), .en(en), .jk_req(jk_req),
        .bad_par(bad_par), .req_ready(req_ready), .req_valid(req_valid),
        .req_pair(req_pair), .req_jk(req_jk), .req_parity(req_parity));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [9:0] exp, input logic [9:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : check
    task automatic complete_run();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        cb_addr  <= ad;
        cb_wdata <= d;
        cb_wr    <= 1'b1;
        @(posedge clk);
        cb_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad);
        @(posedge clk);
        cb_addr <= ad;
        cb_rd   <= 1'b1;
        @(posedge clk);
        cb_rd <= 1'b0;
        #1 v = cb_rdata;
    endtask : rd
    task automatic send(input logic jk, input logic bad);
        @(posedge clk);
        en      <= 1'b1;
        jk_req  <= jk;
        bad_par <= bad;
        @(posedge clk);
        en      <= 1'b0;
        jk_req  <= 1'b0;
        bad_par <= 1'b0;
    endtask : send
    task automatic set_mode(input logic [7:0] d);
        md = 9;
        wr(`FSIC_ADDR_TSC, d);
        cyc(24);
        md = d[4:3];
    endtask : set_mode
    function automatic int exp_inj(input int n, input int s);
        return s / (n + 1);
    endfunction : exp_inj
    task automatic count_inj(input int c, input int n);
        @(negedge clk);
        s0 = slots;
        i0 = injs;
        repeat (c) @(negedge clk);
        check("slot count", c / 8, slots - s0);
        check("inject count", exp_inj(n, c / 8), injs - i0);
    endtask : count_inj

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (req_valid && req_ready) q.push_back(req_pair);
        if (req_valid && req_ready && req_jk) jk_val = req_pair;
        if (cb_write_reject === 1'b1) rejs++;
        if (parity_error === 1'b1) pes++;
        if (tx_valid === 1'b1) begin
            slots++;
            if (tx_injected === 1'b1) begin
                injs++;
                is = slots;
                check("injected pair", {sym_a, sym_b}, tx_pair);
                if (md == 1 && q.size() > 0) void'(q.pop_front());
            end else if (tx_pair !== `FSIC_IDLE_PAIR) begin
                if (tx_pair === jk_val) js = slots;
                check("data pair", q.size() > 0 ? q.pop_front() : 10'h3FF, tx_pair);
            end
            if (md == 0 || md == 3) check("inject flag", md == 3, tx_injected);
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {rstn, cb_wr, cb_rd, trig_copy_busy, en, jk_req, bad_par} = '0;
        cb_addr = 8'h00;
        cb_wdata = 8'h00;
        md = 9;
        js = -1;
        jk_val = 10'h3FF;
        void'($urandom(91078));
        sym_a = 5'($urandom_range(31));
        sym_b = 5'($urandom_range(31));
        cyc(16);
        rstn <= 1'b1;
        rd(`FSIC_ADDR_TSC);
        check("tsc reset", `FSIC_TSC_RESET, v);
        rd(`FSIC_ADDR_CNT);
        check("counter reset", `FSIC_CNT_RESET, v);
        rd(8'h3C);
        check("unmapped", 8'h00, v);
        check("smoother reset", 1'b1, smoother_on);
        set_mode(8'h20);
        a = 8'($urandom_range(255));
        wr(`FSIC_ADDR_THR, a);
        rd(`FSIC_ADDR_THR);
        check("threshold", a, v);
        rd(`FSIC_ADDR_CNT);
        check("reload", a, v);
        cyc(16);
        rd(`FSIC_ADDR_CNT);
        check("idle counter", a, v);
        @(posedge clk);
        en <= 1'b1;
        for (k = 0; k < 400 && req_ready !== 1'b0; k++) @(posedge clk);
        check("fifo full", 1'b0, req_ready);
        if (k == 400) complete_run();
        en <= 1'b0;
        cyc(320);
        check("drained", 0, q.size());
        set_mode(8'h60);
        check("parity on", 1'b1, request_parity_on);
        i0 = pes;
        send(1'b0, 1'b1);
        cyc(20);
        check("parity error", 1, pes - i0);
        set_mode(8'h20);
        send(1'b0, 1'b1);
        cyc(20);
        check("parity off", 1, pes - i0);
        set_mode(8'h00);
        check("smoother off", 1'b0, smoother_on);
        s0 = slots;
        cyc(40);
        check("no fill", 0, slots - s0);
        i0 = rejs;
        trig_copy_busy <= 1'b1;
        wr(`FSIC_ADDR_TSC, 8'h38);
        cyc(3);
        trig_copy_busy <= 1'b0;
        check("reject", 1, rejs - i0);
        rd(`FSIC_ADDR_TSC);
        check("refused write", 8'h00, v);
        set_mode(8'h38);
        count_inj(80, 0);
        wr(`FSIC_ADDR_THR, 8'h00);
        set_mode(8'h30);
        count_inj(80, 0);
        wr(`FSIC_ADDR_THR, 8'h02);
        cyc(24);
        count_inj(96, 2);
        wr(`FSIC_ADDR_THR, 8'h40);
        rd(`FSIC_ADDR_CNT);
        a = v;
        cyc(78);
        rd(`FSIC_ADDR_CNT);
        check("decrement", a - 8'h0A, v);
        for (int n = 0; n < 3; n += 2) begin
            wr(`FSIC_ADDR_THR, 8'(n));
            set_mode(8'h2D);
            js = -1;
            i0 = injs;
            send(1'b1, 1'b0);
            for (k = 0; k < 200 && injs == i0; k++) @(posedge clk);
            cyc(16);
            check("one shot", 1, injs - i0);
            if (k == 200) complete_run();
            check("shot place", n, (n == 0) ? js + 1 : is - js);
            rd(`FSIC_ADDR_TSC);
            check("self clear", 8'h25, v);
            check("tx mode kept", 3'h5, tx_mode);
        end
        complete_run();
    end
endmodule : fsic_top_bench
